// ---- phy_quick_poll_map.vh ----
// register offsets, field positions and reset values of the quick-poll status block
// Function
// [RL1] bypass bit 0 scrambles and descrambles; bit 1 bypasses both paths
// [RL2] scrambler acts only at 100 Mbit; bypass has no effect at 10 Mbit
// [RL3] reserved control bits read zero; station writes their defaults
// [RL4] quick-poll register is 16-bit read-only, writes ignored, reset loads defaults
// [RL5] station writes default value into reserved bits of quick-poll register; the station model passes data to register 17 unmasked
// [RL6] rate bit from rate pin (hardware) or control 0.13 (software), not link
// [RL7] duplex bit from duplex pin (hardware) or control 0.8 (software), not link
// [RL8] progress bits cleared on reset, negotiation disabled or restarted
// [RL9] progress bits hold highest code, change only when new code larger
// [RL10] read returns recorded progress, then loads present state for next read
// [RL11] progress codes 000 to 111, success is complete flag with code 000
// [RL12] signal-lost bit latches high until read
// [RL13] pll lock error bit latches high until read
// [RL14] false carrier bit reads 0 normally, 1 on false carrier
// [RL15] invalid symbol bit latches high until read
// [RL16] halt symbol bit latches high until read
// [RL17] premature end bit latches on two idles in packet, until read
// [RL18] complete bit is 1 only once negotiation finished
// [RL19] remote fault bit latches high until read
// [RL20] event flags latch high until read; link bit latches low
// [RL21] latches clear only at read completion; events during read stay pending
`ifndef PHY_QUICK_POLL_MAP_VH
`define PHY_QUICK_POLL_MAP_VH
`define QP_REG_CTRL16      5'h10
`define QP_REG_STATUS17    5'h11
`define QP_BIT_RATE        15
`define QP_BIT_DUPLEX      14
`define QP_BIT_PROG_HI     13
`define QP_BIT_PROG_LO     11
`define QP_BIT_SIG_LOST    10
`define QP_BIT_PLL_ERR     9
`define QP_BIT_FALSE_CAR   8
`define QP_BIT_INV_SYM     7
`define QP_BIT_HALT_SYM    6
`define QP_BIT_PREM_END    5
`define QP_BIT_AN_DONE     4
`define QP_BIT_SIG_DET     3
`define QP_BIT_JABBER      2
`define QP_BIT_RFAULT      1
`define QP_BIT_LINK        0
`define QP_BIT_BYPASS      0
`define QP_CTRL16_MASK     16'h0001
`define QP_CTRL16_RESET    16'h0000
`define QP_AN_SUCCESS      4'h8
`endif

// ---- phy_quick_poll_status.v ----
// quick-poll detailed status register and scrambler bypass control
`timescale 1ns/1ps
`default_nettype none
`include "phy_quick_poll_map.vh"
module phy_quick_poll_status
(
    input  wire        clk,
    input  wire        rst,
    input  wire [4:0]  reg_addr,
    input  wire        reg_wr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    input  wire        sw_mode,
    input  wire        rate_select_pin,
    input  wire        duplex_select_pin,
    input  wire        ctrl_rate,
    input  wire        ctrl_duplex,
    input  wire        an_enable,
    input  wire        an_restart,
    input  wire [3:0]  an_state,
    input  wire        ev_sig_lost,
    input  wire        ev_pll_err,
    input  wire        ev_false_car,
    input  wire        ev_inv_sym,
    input  wire        ev_halt_sym,
    input  wire        ev_prem_end,
    input  wire        sig_detect,
    input  wire        ev_jabber,
    input  wire        ev_rfault,
    input  wire        link_ok,
    output wire        scramble_en,
    output wire        rate_100
);
    ////////////////////////////////////////////////////////////////////////
    // register number match, shared by the write and read decoders
    // keeps every decoder on one and the same compare
    function reg_hit;
        input [4:0] addr;
        input [4:0] num;
        begin
            reg_hit = (addr == num);
        end
    endfunction

    // latching-high update: a read clears, a new event always wins
    // so an event in the read cycle is reported by the next read
    function [7:0] latch_high;
        input [7:0] held;
        input       clr;
        input [7:0] ev;
        begin
            latch_high = (clr ? 8'h00 : held) | ev;
        end
    endfunction

    // latching-low update: a read reloads from the live level
    // a drop during the read cycle stays low for the next read
    function latch_low;
        input held;
        input clr;
        input lvl;
        begin
            latch_low = (clr ? 1'b1 : held) & lvl;
        end
    endfunction

    // next {complete, code}: clear, then read reload, then success, then climb
    // the code freezes once complete until a read reloads it
    function [3:0] prog_next;
        input       clr;
        input       rd;
        input [3:0] st;
        input       done;
        input [2:0] prog;
        begin
            if (clr)
                prog_next = 4'h0;                                   // [RL8]
            else if (rd)
                prog_next = {(st == `QP_AN_SUCCESS), st[2:0]};      // [RL10]
            else if (st == `QP_AN_SUCCESS)
                prog_next = `QP_AN_SUCCESS;                         // [RL11] [RL18]
            else if (!done && st[2:0] > prog)
                prog_next = {1'b0, st[2:0]};                        // [RL9]
            else
                prog_next = {done, prog};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    reg [1:0] rate_pin_ff;
    reg [1:0] dpx_pin_ff;
    reg        bypass_ff;
    reg [2:0]  prog_ff;
    reg        done_ff;
    reg [7:0]  lh_ff;
    reg        link_ff;
    reg [2:0]  nxt_prog;
    reg        nxt_done;
    reg [7:0]  nxt_lh;
    reg        nxt_link;
    wire       rd_status;
    wire [7:0] lh_ev;
    wire       wr_ctrl;
    wire       an_clear;
    wire [15:0] status_word;
    wire [15:0] ctrl_word;
    reg  [15:0] rd_word;

    always @(posedge clk)
    begin
        if (rst)
        begin
            rate_pin_ff <= 2'b00;
            dpx_pin_ff  <= 2'b00;
        end
        else
        begin
            rate_pin_ff <= {rate_pin_ff[0], rate_select_pin};
            dpx_pin_ff  <= {dpx_pin_ff[0], duplex_select_pin};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register 16, only the bypass bit is stored
    always @(posedge clk)
    begin
        if (rst)
            bypass_ff <= 1'b0;
        else if (wr_ctrl)
            bypass_ff <= reg_wdata[`QP_BIT_BYPASS]; // [RL1]
    end

    // selected rate and duplex, independent of link
    assign rate_100 = sw_mode ? ctrl_rate : rate_pin_ff[1];          // [RL6]
    wire   duplex_full = sw_mode ? ctrl_duplex : dpx_pin_ff[1];       // [RL7]
    // scrambling only at 100 Mbit and not bypassed
    assign scramble_en = rate_100 & ~bypass_ff;                       // [RL1] [RL2]

    ////////////////////////////////////////////////////////////////////////
    // latched bits; clear on read of register 17, new events win
    assign rd_status = reg_rd && reg_hit(reg_addr, `QP_REG_STATUS17);
    assign wr_ctrl   = reg_wr && reg_hit(reg_addr, `QP_REG_CTRL16);
    assign an_clear  = !an_enable || an_restart;                     // [RL8]
    assign lh_ev = {ev_sig_lost, ev_pll_err, ev_false_car, ev_inv_sym,
                    ev_halt_sym, ev_prem_end, ev_jabber, ev_rfault};

    // next values of the latches and of the progress monitor
    always @*
    begin
        // [RL12] [RL13] [RL14] [RL15] [RL16] [RL17] [RL19] [RL21]
        nxt_lh   = latch_high(lh_ff, rd_status, lh_ev);
        nxt_link = latch_low(link_ff, rd_status, link_ok);           // [RL20] [RL21]
        {nxt_done, nxt_prog} = prog_next(an_clear, rd_status, an_state, done_ff, prog_ff);
    end

    // event latches and link latch
    always @(posedge clk)
    begin
        if (rst)
        begin
            lh_ff   <= 8'h00;                                        // [RL4]
            link_ff <= 1'b0;
        end
        else
        begin
            lh_ff   <= nxt_lh;
            link_ff <= nxt_link;
        end
    end

    // progress monitor flops
    always @(posedge clk)
    begin
        if (rst)
        begin
            prog_ff <= 3'h0;                                         // [RL8]
            done_ff <= 1'b0;
        end
        else
        begin
            prog_ff <= nxt_prog;
            done_ff <= nxt_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // quick-poll word, field by field from bit 15 down
    assign status_word = {rate_100,        // [RL6] selected rate
                          duplex_full,     // [RL7] selected duplex
                          prog_ff,         // [RL9] [RL11] progress code
                          lh_ff[7],        // [RL12] signal lost
                          lh_ff[6],        // [RL13] pll lock error
                          lh_ff[5],        // [RL14] false carrier
                          lh_ff[4],        // [RL15] invalid symbol
                          lh_ff[3],        // [RL16] halt symbol
                          lh_ff[2],        // [RL17] premature end
                          done_ff,         // [RL18] negotiation complete
                          sig_detect,      // live signal detect
                          lh_ff[1],        // jabber
                          lh_ff[0],        // [RL19] remote fault
                          link_ff};        // [RL20] link, latching low

    // control word: only the bypass bit is stored, reserved bits read zero
    assign ctrl_word = {15'h0000, bypass_ff} & `QP_CTRL16_MASK;      // [RL3]

    // read multiplexer; unmapped numbers read as zero
    always @*
    begin
        if (reg_hit(reg_addr, `QP_REG_STATUS17))
            rd_word = status_word;                                   // [RL4]
        else if (reg_hit(reg_addr, `QP_REG_CTRL16))
            rd_word = ctrl_word;                                     // [RL3]
        else
            rd_word = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, registered; writes to register 17 are ignored
    always @(posedge clk)
    begin
        if (rst)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
            reg_rdata <= rd_word;                                    // [RL4]
    end
endmodule
`default_nettype wire

// ---- qp_monitor.sv ----
// assertion checker for the quick-poll status block
`timescale 1ns/1ps
`default_nettype none
module qp_monitor
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [4:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        an_enable,
    input wire logic        ev_halt_sym,
    input wire logic        link_ok,
    input wire logic        sw_mode,
    input wire logic        ctrl_rate,
    input wire logic        scramble_en,
    input wire logic        rate_100
);
    wire rd17 = reg_rd && reg_addr == 5'h11;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_rdata_stands: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
    a_no_scr10: assert property (!rate_100 |-> !scramble_en) else $error("scrambler at 10M");
    a_rate_sw: assert property (sw_mode |-> rate_100 == ctrl_rate) else $error("rate wrong");
    a_rsv_zero: assert property (reg_rd && reg_addr == 5'h10 |=> reg_rdata[15:1] == 15'h0000)
        else $error("reserved bits set");
    a_ev_latch: assert property (ev_halt_sym ##1 rd17 |=> reg_rdata[6]) else $error("halt lost");
    a_ev_clear: assert property (rd17 && !ev_halt_sym ##1 rd17 |=> !reg_rdata[6])
        else $error("halt not cleared");
    a_link_low: assert property (!link_ok ##1 rd17 |=> !reg_rdata[0]) else $error("link drop lost");
    a_an_clear: assert property (!an_enable ##1 rd17 |=> reg_rdata[13:11] == 3'h0)
        else $error("progress not cleared");
    c_b2b: cover property (rd17 ##1 rd17);
    c_ev: cover property (ev_halt_sym ##1 rd17);
    c_done: cover property (rd17 ##1 reg_rdata[4]);
endmodule
bind phy_quick_poll_status qp_monitor u_mon(.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .an_enable(an_enable), .ev_halt_sym(ev_halt_sym),
    .link_ok(link_ok), .sw_mode(sw_mode), .ctrl_rate(ctrl_rate), .scramble_en(scramble_en),
    .rate_100(rate_100));
`default_nettype wire

// ---- mgmt_station.sv ----
// management station model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module mgmt_station
(
    input  wire logic        clk,
    output var  logic [4:0]  reg_addr,
    output var  logic        reg_wr,
    output var  logic [15:0] reg_wdata,
    output var  logic        reg_rd
);
    initial {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
    // one access per cycle, held through the sampling edge
    task automatic op(input logic r, input logic w, input logic [4:0] a, input logic [15:0] d);
        reg_rd = r;
        reg_wr = w;
        reg_addr = a;
        reg_wdata = (a == 5'h10) ? (d & 16'h0001) : d;
        @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

// ---- phy_quick_poll_status_tb_top.sv ----
// self-checking bench for the quick-poll status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("Error %0t got %h exp %h", $time, a, b); end end
module phy_quick_poll_status_tb_top;
    logic        clk = 0, rst = 1, sw = 1, rpin = 0, rate = 1, dpx = 0, an_en = 1, link = 1;
    logic [3:0]  an_st = 0;
    logic        dpin = 0, an_rs = 0;
    logic [7:0]  ev = 0;
    logic [15:0] rdata, wd, wdat, q[$];
    logic [4:0]  addr;
    logic        wr, rd, rd_d = 0, scr, r100;
    int          error_cnt = 0, cmp_count = 0, cyc = 0, seed = 67;
    always #5 clk = ~clk;
    mgmt_station u_sta(.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdat), .reg_rd(rd));
    phy_quick_poll_status u_dut(.clk(clk), .rst(rst), .reg_addr(addr), .reg_wr(wr),
        .reg_wdata(wdat), .reg_rd(rd), .reg_rdata(rdata), .sw_mode(sw), .rate_select_pin(rpin),
        .duplex_select_pin(dpin), .ctrl_rate(rate), .ctrl_duplex(dpx), .an_enable(an_en),
        .an_restart(an_rs), .an_state(an_st), .ev_sig_lost(ev[7]), .ev_pll_err(ev[6]),
        .ev_false_car(ev[5]), .ev_inv_sym(ev[4]), .ev_halt_sym(ev[3]), .ev_prem_end(ev[2]),
        .sig_detect(1'b1), .ev_jabber(ev[1]), .ev_rfault(ev[0]), .link_ok(link),
        .scramble_en(scr), .rate_100(r100));
    // expected quick-poll word from bench state
    function automatic logic [15:0] w(input logic [3:0] p, input logic [7:0] e, input logic l);
        w = {rate, dpx, p[2:0], e[7:2], p[3], 1'b1, e[1:0], l};
    endfunction
    task automatic rd17(input logic [15:0] e);
        q.push_back(e);
        u_sta.op(1, 0, 5'h11, 16'h0000);
    endtask
    task automatic finish_test;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // result watcher and cycle limit
    always @(posedge clk)
    begin
        if (rd_d) `CHK(rdata, q.pop_front())
        rd_d <= rd;
        if (++cyc == 3000)
        begin
            error_cnt++;
            finish_test();
        end
    end
    initial
    begin
        repeat (10) @(posedge clk);
        #1 rst = 0;
        rd17(w(0, 0, 0));
        rd17(w(0, 0, 1));
        link = 0;
        u_sta.op(0, 0, 0, 0);
        link = 1;
        rd17(w(0, 0, 0));
        rd17(w(0, 0, 1));
        for (int i = 0; i < 8; i++)
        begin
            wd = $random(seed);
            {rate, dpx} = wd[1:0];
            u_sta.op(0, 1, 5'h11, wd);
            ev = 8'h01 << i;
            rd17(w(0, 0, 1));
            ev = 0;
            rd17(w(0, 8'h01 << i, 1));
            rd17(w(0, 0, 1));
        end
        an_st = 3;
        u_sta.op(0, 0, 0, 0);
        an_st = 1;
        u_sta.op(0, 0, 0, 0);
        rd17(w(3, 0, 1));
        rd17(w(1, 0, 1));
        an_rs = 1;
        u_sta.op(0, 0, 0, 0);
        an_rs = 0;
        rd17(w(0, 0, 1));
        an_en = 0;
        u_sta.op(0, 0, 0, 0);
        rd17(w(0, 0, 1));
        an_en = 1;
        for (int k = 1; k < 9; k++)
        begin
            an_st = k[3:0];
            u_sta.op(0, 0, 0, 0);
            rd17(w(k[3:0], 0, 1));
        end
        rate = 1;
        u_sta.op(0, 1, 5'h10, 16'hffff);
        `CHK(scr, 1'b0)
        q.push_back(16'h0001);
        u_sta.op(1, 0, 5'h10, 0);
        q.push_back(16'h0000);
        u_sta.op(1, 1, 5'h03, 0);
        u_sta.op(0, 1, 5'h10, 0);
        `CHK(scr, 1'b1)
        rate = 0;
        #1 `CHK(scr, 1'b0)
        sw = 0;
        rpin = 1;
        dpin = 1;
        repeat (3) u_sta.op(0, 0, 0, 0);
        `CHK(r100, 1'b1)
        {rate, dpx} = 2'b11;
        rd17(w(4'h8, 0, 1));
        u_sta.op(0, 0, 0, 0);
        finish_test();
    end
endmodule
`default_nettype wire
